// ===== rtl/spbi_top.sv
// Summary of operation
// [R1] Address/data lines carry address in address phase, data in data phases.
// [R2] Command/byte-enable lines carry command, then active-low byte enables.
// [R3] Parity line is even parity over 32 data bits and 4 enables.
// [R4] Parity appears one clock after the address or data it covers.
// [R5] Bridge drives parity whenever it drives address or data.
// [R6] Initiator holds FRAME asserted; deasserting it marks the final data phase.
// [R7] Data phase completes only when both ready signals are sampled asserted.
// [R8] Bridge asserts DEVSEL only after an address decode match.
// [R9] STOP with TRDY and DEVSEL means disconnect with data.
// [R10] STOP with DEVSEL, no TRDY: disconnect without data; retry if first phase.
// [R11] STOP without DEVSEL means target abort.
// [R12] After driving STOP, on idle drive it high one clock, then release.
// [R13] Locked transaction: LOCK high in first address phase, asserted one clock later.
// [R14] Locked transactions are never propagated upstream.
// [R15] Hold LOCK until next locked address phase or release; then drive high once.
// [R16] PERR asserted on received data parity error, two clocks after the data.
// [R17] PERR reported by target on writes, by initiator on reads.
// [R18] After driving PERR, on idle drive it high one clock, then release.
// [R19] Other agents may pull the system-error line low.
// [R20] Secondary system-error line is input only, never driven.
// [R21] System-error input is sampled and forwarded when enabled.
// [R22] Secondary system-error is one cause of the primary system-error output.
// [R23] System-error input is synchronised before forwarding.
// [R24] Parity errors and terminations are passed on as status flags.
`timescale 1ns/100ps
`default_nettype none
module spbi_top
	import spbi_pkg::*;
(
	input wire logic mclk, // Secondary bus clock
	input wire logic nrst, // Async reset, active low
	input wire logic [31:0] sec_ad_i, // Address/data in
	output logic [31:0] sec_ad_o, // Address/data out
	output logic sec_ad_oe, // Address/data enable
	input wire logic [3:0] sec_cmd_byte_enable_n_i, // Command/enables in
	output logic [3:0] sec_cmd_byte_enable_n_o, // Command/enables out
	output logic sec_cmd_byte_enable_n_oe, // Command/enables enable
	input wire logic sec_parity_bit_i, // Parity in
	output logic sec_parity_bit_o, // Parity out
	output logic sec_parity_bit_oe, // Parity enable
	input wire logic sec_frame_n_i, // Frame in
	output logic sec_frame_n_o, // Frame out
	output logic sec_frame_n_oe, // Frame enable
	input wire logic sec_initiator_ready_n_i, // Initiator ready in
	output logic sec_initiator_ready_n_o, // Initiator ready out
	output logic sec_initiator_ready_n_oe, // Initiator ready enable
	input wire logic sec_target_ready_n_i, // Target ready in
	output logic sec_target_ready_n_o, // Target ready out
	output logic sec_target_ready_n_oe, // Target ready enable
	input wire logic sec_device_select_n_i, // Device select in
	output logic sec_device_select_n_o, // Device select out
	output logic sec_device_select_n_oe, // Device select enable
	input wire logic sec_stop_n_i, // Stop in
	output logic sec_stop_n_o, // Stop out
	output logic sec_stop_n_oe, // Stop enable
	output logic sec_lock_n_o, // Lock out
	output logic sec_lock_n_oe, // Lock enable
	input wire logic sec_data_parity_err_n_i, // Parity error in
	output logic sec_data_parity_err_n_o, // Parity error out
	output logic sec_data_parity_err_n_oe, // Parity error enable
	input wire logic sec_system_err_in_n, // System error input only
	input wire logic serr_fwd_en, // Forwarding enable
	output logic pri_system_err_out_n_o, // Primary system error out
	output logic pri_system_err_out_n_oe, // Primary system error enable
	input wire logic req_valid, // Initiator request valid
	input wire spbi_req_t req, // Initiator request
	output logic req_ready, // Request accepted
	input wire logic wr_valid, // Write word valid
	input wire spbi_word_t wr_word, // Write word
	output logic wr_ready, // Write word taken
	output logic rd_valid, // Read word out valid
	output logic [31:0] rd_data, // Read word out
	output logic done, // Initiator transaction ended
	input wire logic lock_release, // Release downstream lock
	input wire logic tgt_hit, // Address decode match
	input wire logic tgt_ready, // Target data available or sink ready
	input wire logic tgt_retry, // Target wants retry
	input wire logic [31:0] tgt_rd_data, // Target read data
	output logic tgt_wr_valid, // Target write word
	output logic [31:0] tgt_wr_data, // Target write data
	output logic [3:0] tgt_wr_be_n, // Target write enables
	output logic [31:0] tgt_addr, // Captured target address
	output logic [3:0] tgt_cmd, // Captured target command
	output logic tgt_busy, // Target transaction in progress
	output spbi_stat_t status // One-cycle status pulses
);

	spbi_state_t st_q;
	logic [31:0] ad_o_q;
	logic [3:0] cbe_o_q;
	logic ad_oe_q, par_o_q, par_oe_q;
	logic frame_o_q, frame_oe_q, irdy_o_q, irdy_oe_q;
	logic trdy_o_q, trdy_oe_q, dsel_o_q, dsel_oe_q;
	logic stop_o_q, stop_oe_q, stop_drv_q;
	logic lock_o_q, lock_oe_q, lock_own_q, lock_pend_q, lock_rel_q;
	logic perr_o_q, perr_oe_q, perr_drv_q;
	logic first_q, rd_q, last_q;
	logic chk_q, exp_par_q;
	logic [31:0] ad_in_q;
	logic [3:0] cbe_in_q;
	logic rd_valid_q, done_q;
	logic [31:0] rd_data_q, tgt_wr_data_q, tgt_addr_q;
	logic [3:0] tgt_wr_be_q, tgt_cmd_q;
	logic tgt_wr_valid_q, tgt_rd_q;
	spbi_stat_t stat_q;
	logic [2:0] serr_sync_q;
	logic serr_q;

	logic bus_idle, xfer, stop_seen, devsel_seen, trdy_seen;
	logic tgt_start;

	// Bus idle when neither frame nor initiator ready is asserted
	assign bus_idle = sec_frame_n_i && sec_initiator_ready_n_i;
	assign xfer = !sec_initiator_ready_n_i && !sec_target_ready_n_i; // [R7]
	assign stop_seen = !sec_stop_n_i;
	assign devsel_seen = !sec_device_select_n_i;
	assign trdy_seen = !sec_target_ready_n_i;
	assign tgt_start = (st_q == ST_IDLE) && !req_valid && !sec_frame_n_i && tgt_hit;
	assign req_ready = (st_q == ST_IDLE) && req_valid && bus_idle;
	// A word is taken whenever it is loaded onto the bus, including the first one in the address cycle
	assign wr_ready = !rd_q && ((st_q == ST_ADDR) || ((st_q == ST_DATA) && (xfer || irdy_o_q) && !(xfer && last_q) && !stop_seen));

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			ad_o_q <= 32'h0000_0000;
			cbe_o_q <= 4'hf;
			ad_oe_q <= 1'b0;
			frame_o_q <= 1'b1;
			frame_oe_q <= 1'b0;
			irdy_o_q <= 1'b1;
			irdy_oe_q <= 1'b0;
			trdy_o_q <= 1'b1;
			trdy_oe_q <= 1'b0;
			dsel_o_q <= 1'b1;
			dsel_oe_q <= 1'b0;
			first_q <= 1'b0;
			rd_q <= 1'b0;
			last_q <= 1'b0;
			tgt_rd_q <= 1'b0;
			tgt_addr_q <= 32'h0000_0000;
			tgt_cmd_q <= 4'h0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (req_ready) begin
						st_q <= ST_ADDR;
						ad_o_q <= req.addr; // [R1]
						cbe_o_q <= req.cmd; // [R2]
						ad_oe_q <= 1'b1;
						frame_o_q <= 1'b0; // [R6]
						frame_oe_q <= 1'b1;
						irdy_o_q <= 1'b1;
						irdy_oe_q <= 1'b1;
						rd_q <= req.read;
						first_q <= 1'b1;
					end else if (tgt_start) begin
						st_q <= ST_TGT;
						tgt_addr_q <= sec_ad_i;
						tgt_cmd_q <= sec_cmd_byte_enable_n_i;
						tgt_rd_q <= !sec_cmd_byte_enable_n_i[0];
						dsel_o_q <= 1'b0; // [R8]
						dsel_oe_q <= 1'b1;
						trdy_o_q <= 1'b1;
						trdy_oe_q <= 1'b1;
						first_q <= 1'b1;
					end
				end
				ST_ADDR: begin
					st_q <= ST_DATA;
					ad_oe_q <= !rd_q;
					ad_o_q <= wr_word.data;
					cbe_o_q <= wr_word.be_n; // [R2]
					irdy_o_q <= !(rd_q || wr_valid);
					frame_o_q <= !rd_q ? wr_word.last : 1'b1; // [R6]
					last_q <= rd_q || wr_word.last;
				end
				ST_DATA: begin
					if (xfer || stop_seen) begin
						first_q <= 1'b0;
					end
					if ((xfer && last_q) || stop_seen) begin // [R9] [R10] [R11]
						st_q <= ST_TURN;
						frame_o_q <= 1'b1;
						irdy_o_q <= 1'b1;
						ad_oe_q <= 1'b0;
					end else if (!rd_q && (xfer || irdy_o_q) && wr_valid) begin
						ad_o_q <= wr_word.data; // [R1]
						cbe_o_q <= wr_word.be_n;
						irdy_o_q <= 1'b0;
						frame_o_q <= wr_word.last; // [R6]
						last_q <= wr_word.last;
					end else if (xfer) begin
						irdy_o_q <= 1'b1;
					end
				end
				ST_TURN: begin
					st_q <= ST_IDLE;
					frame_oe_q <= 1'b0;
					irdy_oe_q <= 1'b0;
					trdy_oe_q <= 1'b0;
					dsel_oe_q <= 1'b0;
					ad_oe_q <= 1'b0;
				end
				ST_TGT: begin
					ad_oe_q <= tgt_rd_q;
					ad_o_q <= tgt_rd_data; // [R1]
					trdy_o_q <= !(tgt_ready && !tgt_retry);
					if (xfer) begin
						first_q <= 1'b0;
					end
					if (sec_frame_n_i && (xfer || !stop_o_q)) begin
						st_q <= ST_TURN;
						trdy_o_q <= 1'b1;
						dsel_o_q <= 1'b1;
						ad_oe_q <= 1'b0;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Target termination: retry drives STOP for the transaction
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stop_o_q <= 1'b1;
			stop_oe_q <= 1'b0;
			stop_drv_q <= 1'b0;
		end else if (st_q == ST_TGT && tgt_retry) begin
			stop_o_q <= 1'b0;
			stop_oe_q <= 1'b1;
			stop_drv_q <= 1'b1;
		end else if (stop_drv_q && !stop_o_q) begin
			stop_o_q <= 1'b1;
		end else if (stop_drv_q && bus_idle) begin // [R12]
			stop_drv_q <= 1'b0;
			stop_oe_q <= 1'b0;
		end
	end

	// Lock is only ever driven downstream; nothing upstream sees it
	always_ff @(posedge mclk or negedge nrst) begin // [R14]
		if (!nrst) begin
			lock_o_q <= 1'b1;
			lock_oe_q <= 1'b0;
			lock_own_q <= 1'b0;
			lock_pend_q <= 1'b0;
			lock_rel_q <= 1'b0;
		end else if (req_ready && req.lock) begin
			lock_o_q <= 1'b1; // [R13]
			lock_oe_q <= 1'b1;
			lock_pend_q <= 1'b1;
			lock_own_q <= 1'b1;
		end else if (lock_pend_q) begin
			lock_o_q <= 1'b0; // [R13]
			lock_pend_q <= 1'b0;
		end else if (lock_own_q && lock_release && bus_idle) begin
			lock_o_q <= 1'b1; // [R15]
			lock_own_q <= 1'b0;
			lock_rel_q <= 1'b1;
		end else if (lock_rel_q) begin
			lock_oe_q <= 1'b0; // [R15]
			lock_rel_q <= 1'b0;
		end
	end

	// Parity follows whatever the bridge drove one clock earlier
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			par_o_q <= 1'b0;
			par_oe_q <= 1'b0;
		end else begin
			// Enables come from the bus: as a target they belong to the far initiator
			par_o_q <= ^{ad_o_q, sec_cmd_byte_enable_n_i}; // [R3] [R4]
			par_oe_q <= ad_oe_q; // [R5]
		end
	end

	// Received data check: reads as initiator, writes as target
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			chk_q <= 1'b0;
			ad_in_q <= 32'h0000_0000;
			cbe_in_q <= 4'h0;
			exp_par_q <= 1'b0;
		end else begin
			chk_q <= xfer && ((st_q == ST_DATA && rd_q) || (st_q == ST_TGT && !tgt_rd_q)); // [R17]
			ad_in_q <= sec_ad_i;
			cbe_in_q <= sec_cmd_byte_enable_n_i;
			exp_par_q <= ^{sec_ad_i, sec_cmd_byte_enable_n_i}; // [R3]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			perr_o_q <= 1'b1;
			perr_oe_q <= 1'b0;
			perr_drv_q <= 1'b0;
		end else if (chk_q && (exp_par_q != sec_parity_bit_i)) begin
			perr_o_q <= 1'b0; // [R16]
			perr_oe_q <= 1'b1;
			perr_drv_q <= 1'b1;
		end else if (perr_drv_q && !perr_o_q) begin
			perr_o_q <= 1'b1;
		end else if (perr_drv_q && bus_idle) begin // [R18]
			perr_drv_q <= 1'b0;
			perr_oe_q <= 1'b0;
		end
	end

	// Data to the queues and termination flags
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 32'h0000_0000;
			tgt_wr_valid_q <= 1'b0;
			tgt_wr_data_q <= 32'h0000_0000;
			tgt_wr_be_q <= 4'hf;
			done_q <= 1'b0;
			stat_q <= '0;
		end else begin
			rd_valid_q <= (st_q == ST_DATA) && rd_q && xfer;
			rd_data_q <= sec_ad_i;
			tgt_wr_valid_q <= (st_q == ST_TGT) && !tgt_rd_q && xfer;
			tgt_wr_data_q <= sec_ad_i;
			tgt_wr_be_q <= sec_cmd_byte_enable_n_i;
			done_q <= (st_q == ST_DATA) && ((xfer && last_q) || stop_seen);
			stat_q.parity_err <= chk_q && (exp_par_q != sec_parity_bit_i); // [R24]
			stat_q.disc_data <= (st_q == ST_DATA) && stop_seen && trdy_seen && devsel_seen; // [R9]
			stat_q.disc_nodata <= (st_q == ST_DATA) && stop_seen && !trdy_seen && devsel_seen && !first_q; // [R10]
			stat_q.retry <= (st_q == ST_DATA) && stop_seen && !trdy_seen && devsel_seen && first_q; // [R10]
			stat_q.target_abort <= (st_q == ST_DATA) && stop_seen && !devsel_seen; // [R11]
		end
	end

	// Three-stage capture; the first stage feeds only the second
	always_ff @(posedge mclk or negedge nrst) begin // [R23]
		if (!nrst) begin
			serr_sync_q <= 3'h7;
			serr_q <= 1'b0;
		end else begin
			serr_sync_q <= {serr_sync_q[1:0], sec_system_err_in_n}; // [R20]
			if (serr_sync_q[1] == serr_sync_q[2]) begin
				serr_q <= !serr_sync_q[2] && serr_fwd_en; // [R21] [R22]
			end
		end
	end

	assign sec_ad_o = ad_o_q;
	assign sec_ad_oe = ad_oe_q;
	assign sec_cmd_byte_enable_n_o = cbe_o_q;
	assign sec_cmd_byte_enable_n_oe = frame_oe_q;
	assign sec_parity_bit_o = par_o_q;
	assign sec_parity_bit_oe = par_oe_q;
	assign sec_frame_n_o = frame_o_q;
	assign sec_frame_n_oe = frame_oe_q;
	assign sec_initiator_ready_n_o = irdy_o_q;
	assign sec_initiator_ready_n_oe = irdy_oe_q;
	assign sec_target_ready_n_o = trdy_o_q;
	assign sec_target_ready_n_oe = trdy_oe_q;
	assign sec_device_select_n_o = dsel_o_q;
	assign sec_device_select_n_oe = dsel_oe_q;
	assign sec_stop_n_o = stop_o_q;
	assign sec_stop_n_oe = stop_oe_q;
	assign sec_lock_n_o = lock_o_q;
	assign sec_lock_n_oe = lock_oe_q;
	assign sec_data_parity_err_n_o = perr_o_q;
	assign sec_data_parity_err_n_oe = perr_oe_q;
	assign pri_system_err_out_n_o = 1'b0;
	assign pri_system_err_out_n_oe = serr_q; // Open drain: only pulls low
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign done = done_q;
	assign tgt_wr_valid = tgt_wr_valid_q;
	assign tgt_wr_data = tgt_wr_data_q;
	assign tgt_wr_be_n = tgt_wr_be_q;
	assign tgt_addr = tgt_addr_q;
	assign tgt_cmd = tgt_cmd_q;
	assign tgt_busy = (st_q == ST_TGT);
	assign status = stat_q;

endmodule
`default_nettype wire

// ===== shared/spbi_pkg.sv
package spbi_pkg;
	localparam int AD_W = 32;
	localparam int CBE_W = 4;
	localparam logic [1:0] TERM_NONE = 2'h0;
	localparam logic [1:0] TERM_DISC_DATA = 2'h1;
	localparam logic [1:0] TERM_DISC_NODATA = 2'h2;
	localparam logic [1:0] TERM_ABORT = 2'h3;

	// Request from the internal queue logic for one initiator transaction
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic lock;
		logic read;
	} spbi_req_t;

	// One data word with its byte enables
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] be_n;
		logic last;
	} spbi_word_t;

	// Status flags passed to the primary side
	typedef struct packed {
		logic parity_err;
		logic retry;
		logic disc_data;
		logic disc_nodata;
		logic target_abort;
	} spbi_stat_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_TURN,
		ST_TGT
	} spbi_state_t;
endpackage

// ===== test/spbi_checker.sv
`timescale 1ns/100ps
`default_nettype none
module spbi_checker
	import spbi_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic nrst, // Reset
	input wire logic [31:0] sec_ad_i, // Bus
	input wire logic [31:0] sec_ad_o, // Drive
	input wire logic sec_ad_oe, // Enable
	input wire logic [3:0] sec_cmd_byte_enable_n_i, // Bus
	input wire logic [3:0] sec_cmd_byte_enable_n_o, // Drive
	input wire logic sec_parity_bit_i, // Bus
	input wire logic sec_parity_bit_o, // Drive
	input wire logic sec_parity_bit_oe, // Enable
	input wire logic sec_frame_n_i, // Bus
	input wire logic sec_frame_n_o, // Drive
	input wire logic sec_initiator_ready_n_o, // Drive
	input wire logic sec_target_ready_n_i, // Bus
	input wire logic sec_device_select_n_o, // Drive
	input wire logic sec_device_select_n_oe, // Enable
	input wire logic sec_stop_n_o, // Drive
	input wire logic sec_stop_n_oe, // Enable
	input wire logic sec_lock_n_o, // Drive
	input wire logic sec_lock_n_oe, // Enable
	input wire logic sec_data_parity_err_n_o, // Drive
	input wire logic sec_data_parity_err_n_oe, // Enable
	input wire logic sec_system_err_in_n, // Input
	input wire logic serr_fwd_en, // Enable
	input wire logic pri_system_err_out_n_o, // Drive
	input wire logic pri_system_err_out_n_oe, // Enable
	input wire logic rd_valid, // Pulse
	input wire logic [31:0] rd_data, // Data
	input wire logic tgt_hit, // Decode
	input wire logic tgt_busy, // Level
	input wire spbi_stat_t status // Pulses
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Parity trails its transfer by one clock, so compare against last cycle's drive
	property p_par;
		sec_ad_oe |=> sec_parity_bit_oe && sec_parity_bit_o == ^{$past(sec_ad_o), $past(sec_cmd_byte_enable_n_i)};
	endproperty
	a_par: assert property (p_par) else $error("parity drive wrong");
	property p_lock; sec_lock_n_oe && sec_lock_n_o && $fell(sec_frame_n_o) |=> !sec_lock_n_o; endproperty
	a_lock: assert property (p_lock) else $error("lock not asserted after address phase");
	property p_lock_rel; $fell(sec_lock_n_oe) |-> $past(sec_lock_n_o); endproperty
	a_lock_rel: assert property (p_lock_rel) else $error("lock released while low");
	property p_stop_rel; $fell(sec_stop_n_oe) |-> $past(sec_stop_n_o) && $past(sec_frame_n_i); endproperty
	a_stop_rel: assert property (p_stop_rel) else $error("stop released badly");
	property p_perr_rel; $fell(sec_data_parity_err_n_oe) |-> $past(sec_data_parity_err_n_o); endproperty
	a_perr_rel: assert property (p_perr_rel) else $error("parity error released while low");
	property p_perr;
		$fell(sec_data_parity_err_n_o) && sec_data_parity_err_n_oe
			|-> ($past(^{sec_ad_i, sec_cmd_byte_enable_n_i}, 2) != $past(sec_parity_bit_i));
	endproperty
	a_perr: assert property (p_perr) else $error("parity error without bad parity");
	property p_devsel; !sec_device_select_n_o && sec_device_select_n_oe |-> tgt_busy; endproperty
	a_devsel: assert property (p_devsel) else $error("device select outside target cycle");
	property p_hit; $rose(tgt_busy) |-> $past(tgt_hit) && !$past(sec_frame_n_i); endproperty
	a_hit: assert property (p_hit) else $error("target start without decode");
	property p_rd;
		rd_valid |-> !$past(sec_initiator_ready_n_o) && !$past(sec_target_ready_n_i) && rd_data == $past(sec_ad_i);
	endproperty
	a_rd: assert property (p_rd) else $error("read word without transfer");
	// The input crosses a synchroniser, so allow seven clocks of settling
	property p_serr; (serr_fwd_en && !sec_system_err_in_n) [*7] |-> pri_system_err_out_n_oe && !pri_system_err_out_n_o; endproperty
	a_serr: assert property (p_serr) else $error("system error not forwarded");
	property p_serr_off; (!serr_fwd_en || sec_system_err_in_n) [*7] |-> !pri_system_err_out_n_oe; endproperty
	a_serr_off: assert property (p_serr_off) else $error("system error forwarded without cause");
	c_retry: cover property (status.retry);
	c_perr: cover property (status.parity_err);
	c_stop: cover property (tgt_busy && sec_stop_n_oe && !sec_stop_n_o);
endmodule
bind spbi_top spbi_checker u_chk (.*);
`default_nettype wire

// ===== test/spbi_far_target.sv
`timescale 1ns/100ps
`default_nettype none
module spbi_far_target (
	input wire logic mclk, // Clock
	input wire logic en, // Respond to frames
	input wire logic frame_n, // Bus level
	input wire logic irdy_n, // Bus level
	input wire logic [31:0] ad, // Bus level
	input wire logic [3:0] cbe_n, // Bus level
	input wire logic [1:0] mode, // 0 normal, 1 retry, 2 abort, 3 disconnect with data
	input wire logic bad_par, // Corrupt read parity
	output logic ds_n, // Device select
	output logic tr_n, // Target ready
	output logic st_n, // Stop
	output logic ad_oe, // Data enable
	output logic [31:0] ad_o, // Read data
	output logic par_oe, // Parity enable
	output logic par_o, // Parity
	output logic [31:0] got_addr, // Address seen
	output logic [3:0] got_cmd, // Command seen
	output logic [31:0] got_data // Last write word
);
	logic act;
	logic rd;
	logic w;
	initial begin
		{ds_n, tr_n, st_n, ad_oe, par_oe, act, w} = 7'h70;
		ad_o = 32'h5a5a_0001;
	end
	always @(posedge mclk) begin
		par_oe <= ad_oe;
		par_o <= ^{ad_o, cbe_n} ^ bad_par;
	end
	always @(posedge mclk) begin
		if (!act) begin
			if (en && !frame_n) begin
				act <= 1'b1;
				got_addr <= ad;
				got_cmd <= cbe_n;
				rd <= !cbe_n[0];
			end
		end else if (frame_n && irdy_n) begin
			act <= 1'b0;
			{ds_n, tr_n, st_n, ad_oe} <= 4'he;
		end else begin
			ds_n <= (mode == 2'h2);
			st_n <= (mode == 2'h0);
			// Normal mode alternates one wait state with one ready clock
			tr_n <= (mode == 2'h0) ? w : (mode != 2'h3);
			w <= ~w;
			ad_oe <= rd;
			if (!irdy_n && !tr_n) begin
				ad_o <= {ad_o[30:0], ~ad_o[31]};
				if (!rd) got_data <= ad;
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/test_secondary_pci_bus_interface.sv
`timescale 1ns/100ps
`default_nettype none
module test_secondary_pci_bus_interface
	import spbi_pkg::*;
;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] sec_ad_i, sec_ad_o, i_ad, m_ad, rd_data, tgt_rd_data, tgt_wr_data, tgt_addr, got_addr, got_data, w_data;
	logic [31:0] ad_last = 32'h0000_0000;
	logic [3:0] sec_cmd_byte_enable_n_i, sec_cmd_byte_enable_n_o, i_cbe, tgt_wr_be_n, tgt_cmd, got_cmd;
	logic sec_ad_oe, sec_cmd_byte_enable_n_oe, sec_parity_bit_i, sec_parity_bit_o, sec_parity_bit_oe, m_poe, m_par;
	logic sec_frame_n_i, sec_frame_n_o, sec_frame_n_oe, sec_initiator_ready_n_i, sec_initiator_ready_n_o;
	logic sec_initiator_ready_n_oe, sec_target_ready_n_i, sec_target_ready_n_o, sec_target_ready_n_oe, m_tr, m_ds;
	logic sec_device_select_n_i, sec_device_select_n_o, sec_device_select_n_oe, sec_stop_n_i, sec_stop_n_o, m_st;
	logic sec_stop_n_oe, sec_lock_n_o, sec_lock_n_oe, sec_data_parity_err_n_i, sec_data_parity_err_n_o;
	logic sec_data_parity_err_n_oe, sec_system_err_in_n, serr_fwd_en, pri_system_err_out_n_o, pri_system_err_out_n_oe;
	logic req_valid, req_ready, wr_valid, wr_ready, rd_valid, done, lock_release, tgt_hit, tgt_ready, tgt_retry;
	logic tgt_wr_valid, tgt_busy, i_par, i_oe, i_fr, i_ir, m_oe, bad, men, did, rd_seen, pe_lo, lk_lo, st_lo, ds_lo;
	logic [1:0] mode;
	spbi_req_t req;
	spbi_word_t wr_word;
	spbi_stat_t status, seen;
	int n_errors = 0;
	int n_compared = 0;
	int idx, n_words;

	// Released address lines show the inverse of their last level, never a held value
	assign sec_ad_i = sec_ad_oe ? sec_ad_o : m_oe ? m_ad : i_oe ? i_ad : ~ad_last;
	assign sec_cmd_byte_enable_n_i = sec_cmd_byte_enable_n_oe ? sec_cmd_byte_enable_n_o : i_oe ? i_cbe : ~ad_last[3:0];
	assign sec_parity_bit_i = sec_parity_bit_oe ? sec_parity_bit_o : m_poe ? m_par : i_par;
	assign sec_frame_n_i = sec_frame_n_oe ? sec_frame_n_o : i_fr;
	assign sec_initiator_ready_n_i = sec_initiator_ready_n_oe ? sec_initiator_ready_n_o : i_ir;
	assign sec_target_ready_n_i = sec_target_ready_n_oe ? sec_target_ready_n_o : m_tr;
	assign sec_device_select_n_i = sec_device_select_n_oe ? sec_device_select_n_o : m_ds;
	assign sec_stop_n_i = sec_stop_n_oe ? sec_stop_n_o : m_st;
	assign sec_data_parity_err_n_i = sec_data_parity_err_n_oe ? sec_data_parity_err_n_o : 1'b1;

	spbi_top DUT (.*);
	spbi_far_target u_far (.mclk(mclk), .en(men), .frame_n(sec_frame_n_i), .irdy_n(sec_initiator_ready_n_i),
		.ad(sec_ad_i), .cbe_n(sec_cmd_byte_enable_n_i), .mode(mode), .bad_par(bad), .ds_n(m_ds), .tr_n(m_tr),
		.st_n(m_st), .ad_oe(m_oe), .ad_o(m_ad), .par_oe(m_poe), .par_o(m_par), .got_addr(got_addr),
		.got_cmd(got_cmd), .got_data(got_data));

	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		ad_last <= sec_ad_i;
		seen <= seen | status;
		did <= did | done;
		rd_seen <= rd_seen | rd_valid;
		pe_lo <= pe_lo | (sec_data_parity_err_n_oe & ~sec_data_parity_err_n_o);
		lk_lo <= lk_lo | (sec_lock_n_oe & ~sec_lock_n_o);
		st_lo <= st_lo | (sec_stop_n_oe & ~sec_stop_n_o);
		ds_lo <= ds_lo | (sec_device_select_n_oe & ~sec_device_select_n_o);
		if (tgt_wr_valid) w_data <= tgt_wr_data;
		if (wr_valid && wr_ready) idx <= idx + 1;
	end
	always @(negedge mclk) begin
		i_par <= ^{i_ad, i_cbe};
		wr_word <= '{data: 32'ha5a5_0000 + idx, be_n: 4'h0, last: idx == n_words - 1};
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task clr;
		@(negedge mclk);
		{seen, did, rd_seen, pe_lo, lk_lo, st_lo, ds_lo} = '0;
	endtask
	task run(input logic [31:0] a, input logic [3:0] c, input logic l, input int n);
		int k;
		@(negedge mclk);
		{n_words, idx} = {n, 32'h0000_0000};
		req = '{addr: a, cmd: c, lock: l, read: !c[0]};
		{req_valid, wr_valid} = 2'h3;
		#1;
		for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge mclk);
		@(negedge mclk);
		req_valid = 1'b0;
		for (k = 0; k < 60 && !did; k++) @(negedge mclk);
		wr_valid = 1'b0;
		chk(did, 1);
	endtask
	task t_write;
		clr;
		run(32'h1000_0040, 4'h7, 1'b0, 2);
		chk(got_addr, 32'h1000_0040);
		chk(got_cmd, 4'h7);
		chk(got_data, 32'ha5a5_0001);
		chk(ds_lo, 0);
	endtask
	task t_read;
		clr;
		bad = 1'b1;
		run(32'h2000_0010, 4'h6, 1'b0, 1);
		repeat (6) @(negedge mclk);
		bad = 1'b0;
		chk(rd_seen, 1);
		chk(seen.parity_err, 1);
		chk(pe_lo, 1);
		chk(sec_data_parity_err_n_oe, 0);
	endtask
	task t_term;
		int m;
		for (m = 1; m < 4; m++) begin
			clr;
			mode = m[1:0];
			run(32'h1000_0080, 4'h7, 1'b0, 2);
			chk({27'h0, seen} & 32'h0000_000d, m == 1 ? 32'h0000_0008 : m == 2 ? 32'h0000_0001 : 32'h0000_0004);
		end
		mode = 2'h0;
	endtask
	task t_lock;
		clr;
		run(32'h3000_0000, 4'h7, 1'b1, 1);
		chk(lk_lo, 1);
		lock_release = 1'b1;
		repeat (6) @(negedge mclk);
		lock_release = 1'b0;
		chk(sec_lock_n_oe, 0);
	endtask
	task t_tgt(input logic rty);
		int k;
		clr;
		{men, tgt_hit, tgt_retry, i_oe, i_fr, i_ad, i_cbe} = {2'h1, rty, 2'h2, 32'h4000_0100, 4'h7};
		@(negedge mclk);
		{i_ad, i_cbe, i_fr, i_ir} = {32'hcafe_0011, 4'h0, 2'h2};
		for (k = 0; k < 20 && sec_target_ready_n_i && sec_stop_n_i; k++) @(negedge mclk);
		@(negedge mclk);
		{i_ir, i_oe, tgt_hit, tgt_retry} = 4'h8;
		repeat (6) @(negedge mclk);
		men = 1'b1;
		chk(tgt_addr, 32'h4000_0100);
		chk(tgt_cmd, 4'h7);
		chk(ds_lo, 1);
		chk(st_lo, rty);
		chk(sec_stop_n_oe, 0);
		if (!rty) chk(w_data, 32'hcafe_0011);
	endtask
	task t_serr;
		{serr_fwd_en, sec_system_err_in_n} = 2'h2;
		repeat (8) @(negedge mclk);
		chk({pri_system_err_out_n_oe, pri_system_err_out_n_o}, 2'h2);
		serr_fwd_en = 1'b0;
		repeat (8) @(negedge mclk);
		chk(pri_system_err_out_n_oe, 0);
		sec_system_err_in_n = 1'b1;
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		{req_valid, wr_valid, lock_release, tgt_hit, tgt_retry, serr_fwd_en, i_oe, bad, mode, i_ad, i_cbe} = '0;
		{tgt_rd_data, req, wr_word, n_words, idx} = '0;
		{tgt_ready, sec_system_err_in_n, i_fr, i_ir, men} = 5'h1f;
		clr;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		nrst = 1'b1;
		t_write;
		t_read;
		t_term;
		t_lock;
		t_tgt(1'b0);
		t_tgt(1'b1);
		t_serr;
		test_done;
	end
	// The sequence needs under a thousand clocks; this cuts a hang at 20000 clocks, well after that
	initial begin
		#100000;
		n_errors++;
		test_done;
	end
endmodule
`default_nettype wire
